// ---- hw/scr_system_control_regs.sv ----
// System control and auxiliary control registers reached by coprocessor accesses.
//
// Overview of operation
// - Replacement policy bit 14 reads zero; writes ignored.
// - Vector select zero gives base 0x00000000, which may be remapped.
// - Vector select one gives fixed base 0xFFFF0000, never remapped.
// - Vector select bit resets from the high table reset input pin.
// - Instruction cache enable bit 12 gates instruction caching; resets to zero.
// - Branch predict bit 11 reads one; prediction active while translation enabled.
// - Swap enable bit 10 zero makes swap instructions undefined; resets zero.
// - Data cache enable bit 2 gates data caching; resets to zero.
// - Alignment check bit 1 enables strict alignment faults; resets zero.
// - Translation enable bit 0 turns the translation unit on; resets zero.
// - Auxiliary control is reachable only from privileged modes.
// - Auxiliary control is one shared copy, fully read-write when secure.
// - Without write grant, non-secure accesses see auxiliary control read-only.
// - With write grant, non-secure writes change only the coherent request bit.
// - Secure writes to auxiliary control under write lock raise undefined.
// - System control uses coprocessor 15, opcode1 0, c1, c0, opcode2 0.
// - System control is banked per security state.
// - Unprivileged system control access raises undefined in either state.
// - Auxiliary control uses the same encoding with opcode2 one.
`timescale 1ns/1ps

module scr_system_control_regs
	import scr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic high_table_reset_input,
	input wire logic secure_cfg_write_lock,
	input wire logic nonsecure_aux_write_grant,
	input wire logic cur_nonsecure,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [3:0] acc_cp_num,
	input wire logic [2:0] acc_opc1,
	input wire logic [3:0] acc_crn,
	input wire logic [3:0] acc_crm,
	input wire logic [2:0] acc_opc2,
	input wire logic acc_privileged,
	input wire logic acc_nonsecure,
	input wire logic [31:0] acc_wdata,
	input wire logic swap_instr_valid,
	output logic acc_done,
	output logic acc_claim,
	output logic acc_undef,
	output logic [31:0] acc_rdata,
	output logic swap_undef,
	output logic [31:0] vector_base,
	output logic vector_remap_allowed,
	output logic icache_en,
	output logic dcache_en,
	output logic align_check_en,
	output logic translation_en,
	output logic branch_predict_active,
	output logic [31:0] aux_control
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [SCR_SYNC_W-1:0] vec_pin_sync;
		logic [SCR_SYNC_W-1:0] lock_sync;
		scr_bank_s sec_bank;
		scr_bank_s ns_bank;
		logic [31:0] aux;
		logic done;
		logic claim;
		logic undef;
		logic swap_undef;
		logic [31:0] rdata;
		logic [31:0] vec_base;
		logic remap_ok;
		logic icache;
		logic dcache;
		logic align;
		logic xlate;
	} scr_state_s;

	scr_state_s st_reg;
	scr_state_s st_next;

	// ----------------------------------------------------------------
	// Read value of one banked copy
	// ----------------------------------------------------------------
	function automatic logic [31:0] scr_sys_view(input scr_bank_s b);
		logic [31:0] v;
		v = SCR_SYS_FIXED_ONES;
		v[SCR_BIT_VEC_HIGH] = b.vec_high;
		v[SCR_BIT_ICACHE] = b.icache;
		v[SCR_BIT_SWAP] = b.swap;
		v[SCR_BIT_DCACHE] = b.dcache;
		v[SCR_BIT_ALIGN] = b.align;
		v[SCR_BIT_XLATE] = b.xlate;
		return v;
	endfunction

	// Only the banked bits take a written value; the rest are fixed.
	function automatic scr_bank_s scr_sys_write(input logic [31:0] d);
		scr_bank_s b;
		b.vec_high = d[SCR_BIT_VEC_HIGH];
		b.icache = d[SCR_BIT_ICACHE];
		b.swap = d[SCR_BIT_SWAP];
		b.dcache = d[SCR_BIT_DCACHE];
		b.align = d[SCR_BIT_ALIGN];
		b.xlate = d[SCR_BIT_XLATE];
		return b;
	endfunction

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	logic enc_common;
	logic hit_sys;
	logic hit_aux;
	logic lock_now;
	scr_bank_s cur_bank;

	always_comb begin
		enc_common = (acc_cp_num == SCR_CP_NUM) && (acc_opc1 == SCR_OPC1)
			&& (acc_crn == SCR_CRN) && (acc_crm == SCR_CRM);
		hit_sys = acc_valid && enc_common && (acc_opc2 == SCR_OPC2_SYS);
		hit_aux = acc_valid && enc_common && (acc_opc2 == SCR_OPC2_AUX);
		lock_now = st_reg.lock_sync[SCR_SYNC_W-1];
		cur_bank = cur_nonsecure ? st_reg.ns_bank : st_reg.sec_bank;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		scr_bank_s eff;
		logic vec_pin;
		eff = '0;
		vec_pin = st_reg.vec_pin_sync[SCR_SYNC_W-1];
		st_next = st_reg;
		// The first flop of each chain feeds only the second one.
		st_next.vec_pin_sync = {st_reg.vec_pin_sync[SCR_SYNC_W-2:0], high_table_reset_input};
		st_next.lock_sync = {st_reg.lock_sync[SCR_SYNC_W-2:0], secure_cfg_write_lock};
		st_next.done = acc_valid;
		st_next.claim = hit_sys || hit_aux;
		st_next.undef = 1'b0;
		st_next.rdata = '0;
		st_next.swap_undef = swap_instr_valid && !cur_bank.swap;

		if (hit_sys) begin
			if (!acc_privileged) begin
				st_next.undef = 1'b1;
			end else if (acc_write && !acc_nonsecure && lock_now) begin
				st_next.undef = 1'b1;
			end else if (acc_write) begin
				if (acc_nonsecure) begin
					st_next.ns_bank = scr_sys_write(acc_wdata);
				end else begin
					st_next.sec_bank = scr_sys_write(acc_wdata);
				end
			end else begin
				st_next.rdata = scr_sys_view(acc_nonsecure ? st_reg.ns_bank : st_reg.sec_bank);
			end
		end

		if (hit_aux) begin
			if (!acc_privileged) begin
				st_next.undef = 1'b1;
			end else if (acc_write && !acc_nonsecure && lock_now) begin
				st_next.undef = 1'b1;
			end else if (acc_write && !acc_nonsecure) begin
				st_next.aux = acc_wdata;
			end else if (acc_write && nonsecure_aux_write_grant) begin
				st_next.aux[SCR_BIT_COHERENT] = acc_wdata[SCR_BIT_COHERENT];
			end else if (!acc_write) begin
				st_next.rdata = st_reg.aux;
			end
			// A non-secure write without the grant changes nothing.
		end

		// Effective controls follow the bank of the current security state.
		eff = cur_nonsecure ? st_next.ns_bank : st_next.sec_bank;
		st_next.vec_base = eff.vec_high ? SCR_VEC_BASE_HIGH : SCR_VEC_BASE_LOW;
		st_next.remap_ok = !eff.vec_high;
		st_next.icache = eff.icache;
		st_next.dcache = eff.dcache;
		st_next.align = eff.align;
		st_next.xlate = eff.xlate;

		if (reset) begin
			// Reset is held for at least three edges so the pin level is settled.
			st_next.sec_bank = '{vec_high: vec_pin, icache: SCR_ICACHE_RST,
				swap: SCR_SWAP_RST, dcache: SCR_DCACHE_RST,
				align: SCR_ALIGN_RST, xlate: SCR_XLATE_RST};
			st_next.ns_bank = st_next.sec_bank;
			st_next.lock_sync = '0;
			st_next.aux = SCR_AUX_RST;
			st_next.done = 1'b0;
			st_next.claim = 1'b0;
			st_next.undef = 1'b0;
			st_next.swap_undef = 1'b0;
			st_next.rdata = '0;
			st_next.vec_base = vec_pin ? SCR_VEC_BASE_HIGH : SCR_VEC_BASE_LOW;
			st_next.remap_ok = !vec_pin;
			st_next.icache = SCR_ICACHE_RST;
			st_next.dcache = SCR_DCACHE_RST;
			st_next.align = SCR_ALIGN_RST;
			st_next.xlate = SCR_XLATE_RST;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign acc_done = st_reg.done;
	assign acc_claim = st_reg.claim;
	assign acc_undef = st_reg.undef;
	assign acc_rdata = st_reg.rdata;
	assign swap_undef = st_reg.swap_undef;
	assign vector_base = st_reg.vec_base;
	assign vector_remap_allowed = st_reg.remap_ok;
	assign icache_en = st_reg.icache;
	assign dcache_en = st_reg.dcache;
	assign align_check_en = st_reg.align;
	assign translation_en = st_reg.xlate;
	assign branch_predict_active = st_reg.xlate;
	assign aux_control = st_reg.aux;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_sys_read;
		hit_sys && !acc_write && acc_privileged;
	endsequence

	sequence s_aux_secure_write;
		hit_aux && acc_write && acc_privileged && !acc_nonsecure;
	endsequence

	a_fixed_sys_bits: assert property (@(posedge ref_clk) disable iff (reset)
		s_sys_read |=> (acc_rdata & 32'hFFFF_CBF8) == SCR_SYS_FIXED_ONES)
		else $error("fixed system control bits read wrong");

	a_repl_zero: assert property (@(posedge ref_clk) disable iff (reset)
		s_sys_read |=> !acc_rdata[SCR_BIT_REPL] && acc_rdata[SCR_BIT_BPRED])
		else $error("replacement or predict bit wrong");

	a_vec_select: assert property (@(posedge ref_clk) disable iff (reset)
		vector_base == (cur_bank.vec_high ? 32'hFFFF0000 : 32'h00000000)
		&& vector_remap_allowed == !cur_bank.vec_high
		|| $changed(cur_nonsecure) || $past(hit_sys))
		else $error("vector base does not follow select bit");

	a_reset_clear: assert property (@(posedge ref_clk)
		$fell(reset) |-> !icache_en && !dcache_en && !align_check_en && !translation_en)
		else $error("controls not cleared by reset");

	a_pred_follows: assert property (@(posedge ref_clk) disable iff (reset)
		branch_predict_active == translation_en)
		else $error("prediction not tied to translation");

	a_swap_undef: assert property (@(posedge ref_clk) disable iff (reset)
		swap_instr_valid && !cur_bank.swap |=> swap_undef)
		else $error("swap not refused while disabled");

	a_unpriv_undef: assert property (@(posedge ref_clk) disable iff (reset)
		acc_valid && (hit_sys || hit_aux) && !acc_privileged |=> acc_undef && acc_done)
		else $error("unprivileged access not refused");

	a_lock_undef: assert property (@(posedge ref_clk) disable iff (reset)
		s_aux_secure_write and lock_now |=> acc_undef && $stable(aux_control))
		else $error("locked secure write not refused");

	a_secure_write: assert property (@(posedge ref_clk) disable iff (reset)
		s_aux_secure_write and !lock_now
		|=> aux_control == $past(acc_wdata))
		else $error("secure write to aux control lost");

	a_ns_readonly: assert property (@(posedge ref_clk) disable iff (reset)
		hit_aux && acc_write && acc_privileged && acc_nonsecure
		&& !nonsecure_aux_write_grant |=> $stable(aux_control) && !acc_undef)
		else $error("non-secure write changed aux control");

	a_ns_grant: assert property (@(posedge ref_clk) disable iff (reset)
		hit_aux && acc_write && acc_privileged && acc_nonsecure && nonsecure_aux_write_grant
		|=> (aux_control ^ $past(aux_control)) == ($past(aux_control ^ acc_wdata) & 32'h40))
		else $error("granted non-secure write touched other bits");

	a_bank_apart: assert property (@(posedge ref_clk) disable iff (reset)
		hit_sys && acc_write && acc_privileged && acc_nonsecure |=> $stable(st_reg.sec_bank))
		else $error("non-secure write altered secure copy");

	// Every request is answered exactly one edge later; idle cycles stay quiet.
	a_done_follows: assert property (@(posedge ref_clk) disable iff (reset)
		acc_valid |=> acc_done)
		else $error("request not answered");

	a_idle_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		!acc_valid |=> !acc_done && !acc_claim && !acc_undef && acc_rdata == 32'h0000_0000)
		else $error("answer without request");

	a_enc_claim: assert property (@(posedge ref_clk) disable iff (reset)
		hit_sys || hit_aux |=> acc_claim)
		else $error("matching encoding not claimed");

	a_enc_miss: assert property (@(posedge ref_clk) disable iff (reset)
		acc_valid && !hit_sys && !hit_aux
		|=> !acc_claim && !acc_undef && acc_rdata == 32'h0000_0000)
		else $error("foreign encoding answered");

	a_write_rdata: assert property (@(posedge ref_clk) disable iff (reset)
		acc_valid && acc_write |=> acc_rdata == 32'h0000_0000)
		else $error("write returned read data");

	a_aux_read: assert property (@(posedge ref_clk) disable iff (reset)
		hit_aux && !acc_write && acc_privileged |=> acc_rdata == $past(aux_control))
		else $error("aux control read wrong");

	// The lock reaches secure system_control writes too, so a locked core cannot rewrite its secure vectors.
	sequence s_sys_secure_write;
		hit_sys && acc_write && acc_privileged && !acc_nonsecure;
	endsequence

	a_sys_lock: assert property (@(posedge ref_clk) disable iff (reset)
		s_sys_secure_write and lock_now |=> acc_undef && $stable(st_reg.sec_bank))
		else $error("locked system control write not refused");

	a_reset_vector: assert property (@(posedge ref_clk)
		$fell(reset) |-> vector_base == ($past(st_reg.vec_pin_sync[SCR_SYNC_W-1])
		? SCR_VEC_BASE_HIGH : SCR_VEC_BASE_LOW)
		&& st_reg.ns_bank.vec_high == st_reg.sec_bank.vec_high)
		else $error("vector select not loaded from pin");

	// A change of security state lets the outputs lag the bank by one edge.
	a_ctrl_bank: assert property (@(posedge ref_clk) disable iff (reset)
		{icache_en, dcache_en, align_check_en, translation_en}
		== {cur_bank.icache, cur_bank.dcache, cur_bank.align, cur_bank.xlate}
		|| $changed(cur_nonsecure))
		else $error("controls do not follow current bank");

	a_swap_allowed: assert property (@(posedge ref_clk) disable iff (reset)
		swap_instr_valid && cur_bank.swap |=> !swap_undef)
		else $error("swap refused while enabled");

endmodule

// ---- inc/scr_pkg.sv ----
// Constants for the system control register bank.
package scr_pkg;

	// ----------------------------------------------------------------
	// Coprocessor access encoding
	// ----------------------------------------------------------------
	localparam logic [3:0] SCR_CP_NUM = 4'hF;
	localparam logic [2:0] SCR_OPC1 = 3'h0;
	localparam logic [3:0] SCR_CRN = 4'h1;
	localparam logic [3:0] SCR_CRM = 4'h0;
	localparam logic [2:0] SCR_OPC2_SYS = 3'h0;
	localparam logic [2:0] SCR_OPC2_AUX = 3'h1;

	// ----------------------------------------------------------------
	// system_control field positions
	// ----------------------------------------------------------------
	localparam int SCR_BIT_REPL = 14;
	localparam int SCR_BIT_VEC_HIGH = 13;
	localparam int SCR_BIT_ICACHE = 12;
	localparam int SCR_BIT_BPRED = 11;
	localparam int SCR_BIT_SWAP = 10;
	localparam int SCR_BIT_DCACHE = 2;
	localparam int SCR_BIT_ALIGN = 1;
	localparam int SCR_BIT_XLATE = 0;

	// Bits 16, 11 and 6 to 3 read as one; every other fixed bit reads as zero.
	localparam logic [31:0] SCR_SYS_FIXED_ONES = 32'h0001_0878;

	// ----------------------------------------------------------------
	// Vector bases and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] SCR_VEC_BASE_LOW = 32'h0000_0000;
	localparam logic [31:0] SCR_VEC_BASE_HIGH = 32'hFFFF_0000;
	localparam logic SCR_ICACHE_RST = 1'h0;
	localparam logic SCR_SWAP_RST = 1'h0;
	localparam logic SCR_DCACHE_RST = 1'h0;
	localparam logic SCR_ALIGN_RST = 1'h0;
	localparam logic SCR_XLATE_RST = 1'h0;

	// ----------------------------------------------------------------
	// aux_control
	// ----------------------------------------------------------------
	localparam int SCR_BIT_COHERENT = 6;
	localparam logic [31:0] SCR_AUX_RST = 32'h0000_0000;

	// One banked copy of the writable system_control bits.
	typedef struct packed {
		logic vec_high;
		logic icache;
		logic swap;
		logic dcache;
		logic align;
		logic xlate;
	} scr_bank_s;

	localparam int SCR_SYNC_W = 2;

endpackage

// ---- tb/scr_core_model.sv ----
// Core pipeline model that issues coprocessor accesses to the register bank.
`timescale 1ns/1ps

module scr_core_model
	import scr_pkg::*;
(
	input wire logic ref_clk,
	output logic acc_valid,
	output logic acc_write,
	output logic [3:0] acc_cp_num,
	output logic [2:0] acc_opc1,
	output logic [3:0] acc_crn,
	output logic [3:0] acc_crm,
	output logic [2:0] acc_opc2,
	output logic acc_privileged,
	output logic acc_nonsecure,
	output logic [31:0] acc_wdata,
	input wire logic acc_done,
	input wire logic acc_claim,
	input wire logic acc_undef,
	input wire logic [31:0] acc_rdata
);
	initial begin
		acc_valid = 1'h0;
		acc_write = 1'h0;
		acc_cp_num = 4'h0;
		acc_opc1 = 3'h7;
		acc_crn = 4'hE;
		acc_crm = 4'hF;
		acc_opc2 = 3'h7;
		acc_privileged = 1'h0;
		acc_nonsecure = 1'h1;
		acc_wdata = 32'h0;
	end

	// ----------------------------------------------------------------
	// Access issue
	// ----------------------------------------------------------------
	// Outside a request wdata, opc2, crn and privilege are scrambled, so a design that
	// latches them late sees garbage instead of a lucky stale value.
	task automatic access(input logic wr, input logic [2:0] opc2, input logic priv,
		input logic ns, input logic [31:0] wd, output logic [31:0] rd,
		output logic claim, output logic undef);
		@(posedge ref_clk);
		acc_valid <= 1'h1;
		acc_write <= wr;
		acc_cp_num <= SCR_CP_NUM;
		acc_opc1 <= SCR_OPC1;
		acc_crn <= SCR_CRN;
		acc_crm <= SCR_CRM;
		acc_opc2 <= opc2;
		acc_privileged <= priv;
		acc_nonsecure <= ns;
		acc_wdata <= wd;
		@(posedge ref_clk);
		acc_valid <= 1'h0;
		acc_wdata <= ~wd;
		acc_opc2 <= ~opc2;
		acc_crn <= ~SCR_CRN;
		acc_privileged <= ~priv;
		#1;
		rd = acc_rdata;
		claim = acc_claim & acc_done;
		undef = acc_undef & acc_done;
	endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking testbench for the system control register bank.
`timescale 1ns/1ps

module testbench;
	import scr_pkg::*;
	localparam logic [31:0] WMASK = 32'h0000_3407;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic pin_hi = 1'h1;
	logic lock = 1'h0;
	logic grant = 1'h0;
	logic cur_ns = 1'h0;
	logic atomic_exchange_word = 1'h0;
	logic acc_valid, acc_write, acc_privileged, acc_nonsecure, acc_done, acc_claim, acc_undef;
	logic [3:0] acc_cp_num, acc_crn, acc_crm;
	logic [2:0] acc_opc1, acc_opc2;
	logic [31:0] acc_wdata, acc_rdata, vector_base, aux_control, rd;
	logic swap_undef, vector_remap_allowed, icache_en, dcache_en, align_check_en;
	logic translation_en, branch_predict_active, cl, un;
	int errors = 0;
	int checked = 0;
	int cycles = 0;

	always #5 ref_clk = ~ref_clk;

	scr_system_control_regs dut(.ref_clk(ref_clk), .reset(reset),
		.high_table_reset_input(pin_hi), .secure_cfg_write_lock(lock),
		.nonsecure_aux_write_grant(grant), .cur_nonsecure(cur_ns), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_cp_num(acc_cp_num), .acc_opc1(acc_opc1),
		.acc_crn(acc_crn), .acc_crm(acc_crm), .acc_opc2(acc_opc2),
		.acc_privileged(acc_privileged), .acc_nonsecure(acc_nonsecure), .acc_wdata(acc_wdata),
		.swap_instr_valid(atomic_exchange_word), .acc_done(acc_done), .acc_claim(acc_claim),
		.acc_undef(acc_undef), .acc_rdata(acc_rdata), .swap_undef(swap_undef),
		.vector_base(vector_base), .vector_remap_allowed(vector_remap_allowed),
		.icache_en(icache_en), .dcache_en(dcache_en), .align_check_en(align_check_en),
		.translation_en(translation_en), .branch_predict_active(branch_predict_active),
		.aux_control(aux_control));

	scr_core_model core(.ref_clk(ref_clk), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_cp_num(acc_cp_num), .acc_opc1(acc_opc1), .acc_crn(acc_crn), .acc_crm(acc_crm),
		.acc_opc2(acc_opc2), .acc_privileged(acc_privileged), .acc_nonsecure(acc_nonsecure),
		.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_claim(acc_claim),
		.acc_undef(acc_undef), .acc_rdata(acc_rdata));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic swap_try(input logic exp);
		@(posedge ref_clk);
		atomic_exchange_word <= 1'h1;
		@(posedge ref_clk);
		atomic_exchange_word <= 1'h0;
		#1;
		check(32'(swap_undef), 32'(exp));
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		core.access(1'h0, SCR_OPC2_SYS, 1'h1, 1'h0, 32'h0, rd, cl, un);
		check(rd, SCR_SYS_FIXED_ONES | 32'h0000_2000);
		check(32'(cl), 32'h1);
		check(32'(un), 32'h0);
		check(32'({icache_en, dcache_en}), 32'h0);
		check(32'({align_check_en, translation_en}), 32'h0);
		check(vector_base, SCR_VEC_BASE_HIGH);
		check(32'(vector_remap_allowed), 32'h0);
		check(aux_control, SCR_AUX_RST);
		swap_try(1'h1);
	endtask

	task automatic t_sys();
		core.access(1'h1, SCR_OPC2_SYS, 1'h1, 1'h0, 32'hFFFF_FFFF, rd, cl, un);
		check(32'(un), 32'h0);
		check(32'({icache_en, dcache_en}), 32'h3);
		check(32'({align_check_en, translation_en}), 32'h3);
		check(32'(branch_predict_active), 32'h1);
		swap_try(1'h0);
		core.access(1'h0, SCR_OPC2_SYS, 1'h1, 1'h0, 32'h0, rd, cl, un);
		check(rd, SCR_SYS_FIXED_ONES | WMASK);
		core.access(1'h1, SCR_OPC2_SYS, 1'h1, 1'h0, 32'h0, rd, cl, un);
		check(vector_base, SCR_VEC_BASE_LOW);
		check(32'(vector_remap_allowed), 32'h1);
		check(32'({icache_en, translation_en, branch_predict_active}), 32'h0);
		swap_try(1'h1);
	endtask

	task automatic t_bank();
		@(posedge ref_clk);
		cur_ns <= 1'h1;
		core.access(1'h1, SCR_OPC2_SYS, 1'h1, 1'h1, 32'h0000_1000, rd, cl, un);
		check(32'({icache_en, dcache_en}), 32'h2);
		check(vector_base, SCR_VEC_BASE_LOW);
		@(posedge ref_clk);
		cur_ns <= 1'h0;
		@(posedge ref_clk);
		#1;
		check(32'(icache_en), 32'h0);
	endtask

	task automatic t_priv();
		core.access(1'h0, SCR_OPC2_SYS, 1'h0, 1'h0, 32'h0, rd, cl, un);
		check(32'(un), 32'h1);
		core.access(1'h1, SCR_OPC2_SYS, 1'h0, 1'h1, 32'hFFFF_FFFF, rd, cl, un);
		check(32'(un), 32'h1);
		core.access(1'h1, SCR_OPC2_AUX, 1'h0, 1'h0, 32'hFFFF_FFFF, rd, cl, un);
		check(32'(un), 32'h1);
		check(aux_control, SCR_AUX_RST);
	endtask

	task automatic t_aux();
		core.access(1'h1, SCR_OPC2_AUX, 1'h1, 1'h0, 32'hFFFF_FFFF, rd, cl, un);
		check(32'({cl, un}), 32'h2);
		check(aux_control, 32'hFFFF_FFFF);
		core.access(1'h1, SCR_OPC2_AUX, 1'h1, 1'h1, 32'h0, rd, cl, un);
		check(32'(un), 32'h0);
		check(aux_control, 32'hFFFF_FFFF);
		core.access(1'h0, SCR_OPC2_AUX, 1'h1, 1'h1, 32'h0, rd, cl, un);
		check(rd, 32'hFFFF_FFFF);
		@(posedge ref_clk);
		grant <= 1'h1;
		core.access(1'h1, SCR_OPC2_AUX, 1'h1, 1'h1, 32'h0, rd, cl, un);
		check(32'(un), 32'h0);
		check(aux_control, 32'hFFFF_FFBF);
	endtask

	task automatic t_lock();
		@(posedge ref_clk);
		lock <= 1'h1;
		repeat (3) @(posedge ref_clk);
		core.access(1'h1, SCR_OPC2_AUX, 1'h1, 1'h0, 32'h0, rd, cl, un);
		check(32'(un), 32'h1);
		check(aux_control, 32'hFFFF_FFBF);
		core.access(1'h1, SCR_OPC2_SYS, 1'h1, 1'h0, 32'hFFFF_FFFF, rd, cl, un);
		check(32'(un), 32'h1);
		check(32'({icache_en, translation_en}), 32'h0);
		core.access(1'h0, 3'h2, 1'h1, 1'h0, 32'h0, rd, cl, un);
		check(32'({cl, un}), 32'h0);
		check(rd, 32'h0);
	endtask

	// A second reset with the pin low must load the low vector into both copies.
	task automatic t_rst2();
		@(posedge ref_clk);
		pin_hi <= 1'h0;
		reset <= 1'h1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'h0;
		#1;
		check(vector_base, SCR_VEC_BASE_LOW);
		check(32'(vector_remap_allowed), 32'h1);
		check(aux_control, SCR_AUX_RST);
		core.access(1'h0, SCR_OPC2_SYS, 1'h1, 1'h1, 32'h0, rd, cl, un);
		check(rd, SCR_SYS_FIXED_ONES);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'h0;
		t_reset();
		t_sys();
		t_bank();
		t_priv();
		t_aux();
		t_lock();
		t_rst2();
		close_out();
	end
endmodule
